// ==== verilog/dind_pkg.sv ====
// Contract
// - Three half-band stages, each doubling rate, cascade to 2x, 4x or 8x.
// - Interpolators filter I and Q apart; modulators treat I/Q as one complex.
// - 8x mode output at most 1.6 GHz, so input at most 200 MHz.
// - First stage is a symmetric 55-tap filter with the fixed integer taps.
// - Second stage is a symmetric 23-tap filter with the fixed integer taps.
// - Third stage is a symmetric 11-tap filter with the fixed integer taps.
// - Coarse mode shifts signal to a quarter of the output sample rate.
// - Fine mode mixes I/Q with a cosine/sine pair and sums the products.
// - Carrier set by 32-bit word in byte registers 0x31 to 0x34.
// - Oscillator advances every converter clock; carrier spans dc to half rate.
// - Tuning word is twos complement; negative carriers wrap from 2^32.
// - Word writes go to shadow; active word changes only on an update.
// - Rising 0x30 bit 0 loads and sets ack bit 1; falling clears ack.
// - Action field 0x22[1:0] selecting oscillator loads word on valid frame pulse.
// - 0x30 bit 6 reads 1 after a frame-triggered update has completed.
// - One-shot acts only on first valid frame pulse after action field write.
// - Interpolation ratio selected by bits 1:0 of register 0x28.
package dind_pkg;

  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } dind_iq_t;

  typedef enum logic [1:0] {
    DIND_R1 = 2'b00,
    DIND_R2 = 2'b01,
    DIND_R4 = 2'b10,
    DIND_R8 = 2'b11
  } dind_ratio_t;

  typedef enum logic [1:0] {
    DIND_MOD_OFF = 2'b00,
    DIND_MOD_FS4 = 2'b01,
    DIND_MOD_NCO = 2'b10
  } dind_mod_t;

  localparam logic [7:0] ADDR_FRAME_CFG = 8'h22;
  localparam logic [7:0] ADDR_RATIO     = 8'h28;
  localparam logic [7:0] ADDR_UPD_CTRL  = 8'h30;
  localparam logic [7:0] ADDR_WORD_A    = 8'h31;
  localparam logic [7:0] ADDR_WORD_D    = 8'h34;

  localparam int FRM_ACTION_LSB = 0;
  localparam int FRM_REPEAT_BIT = 2;
  localparam int UPD_REQ_BIT    = 0;
  localparam int UPD_ACK_BIT    = 1;
  localparam int UPD_FRM_ACK_BIT = 6;

  localparam logic [1:0] ACT_FIFO = 2'h0;
  localparam logic [1:0] ACT_NCO  = 2'h1;
  localparam logic [1:0] ACT_BOTH = 2'h2;

  localparam logic [7:0] RST_FRAME_CFG = 8'h00;
  localparam logic [1:0] RST_RATIO     = 2'h1;
  localparam logic [7:0] RST_WORD_BYTE = 8'h00;

  localparam int SYS_CLK_MHZ = 25;
  localparam int MAX_DAC_MHZ = 1600;
  localparam int MAX_IN_MHZ  = MAX_DAC_MHZ / 8;

  localparam int HB1_TAPS = 55;
  localparam int HB2_TAPS = 23;
  localparam int HB3_TAPS = 11;
  localparam int SINE_SHIFT = 14;

  localparam logic signed [17:0] HB1_ODD [14] = '{-18'sh00004, 18'sh0000D, -18'sh00020,
    18'sh00045, -18'sh00086, 18'sh000EF, -18'sh00191, 18'sh00282, -18'sh003E2,
    18'sh005E8, -18'sh00903, 18'sh00E51, -18'sh019EE, 18'sh05112};
  localparam logic signed [17:0] HB2_ODD [6] = '{-18'sh00002, 18'sh00011, -18'sh0004B,
    18'sh000EE, -18'sh00294, 18'sh009E2};
  localparam logic signed [17:0] HB3_ODD [3] = '{18'sh0001D, -18'sh000D6, 18'sh004B9};
  localparam logic signed [17:0] HB1_CTR = 18'sh08000;
  localparam logic signed [17:0] HB2_CTR = 18'sh01000;
  localparam logic signed [17:0] HB3_CTR = 18'sh00800;

  localparam logic signed [17:0] SINE_LUT [17] = '{18'sh00000, 18'sh00646, 18'sh00C7C,
    18'sh01294, 18'sh0187E, 18'sh01E2B, 18'sh0238E, 18'sh0289A, 18'sh02D41, 18'sh03179,
    18'sh03537, 18'sh03871, 18'sh03B21, 18'sh03D3F, 18'sh03EC5, 18'sh03FB1, 18'sh04000};

  function automatic logic signed [17:0] dind_hb_coef(input int stage, input int k);
    if (stage == 1)
      return HB1_ODD[k];
    else if (stage == 2)
      return HB2_ODD[k];
    else
      return HB3_ODD[k];
  endfunction : dind_hb_coef

  // Quarter-wave fold; 6 phase bits trade spur level for area
  function automatic logic signed [17:0] dind_sine(input logic [5:0] ph);
    logic [4:0] k;
    k = {1'b0, ph[3:0]};
    if (ph[4])
      k = 5'h10 - k;
    return ph[5] ? -SINE_LUT[k] : SINE_LUT[k];
  endfunction : dind_sine

  function automatic logic signed [15:0] dind_sat16(input logic signed [39:0] v);
    if (v > 40'sh0000007FFF)
      return 16'sh7FFF;
    else if (v < -40'sh0000008000)
      return -16'sh8000;
    else
      return v[15:0];
  endfunction : dind_sat16

  function automatic logic dind_strobe(input logic [2:0] cnt, input int span);
    logic [2:0] m;
    m = 3'((1 << span) - 1);
    return (cnt & m) == 3'h0;
  endfunction : dind_strobe

endpackage : dind_pkg

// ==== verilog/dind_halfband.sv ====
`timescale 1ns/1ps
// One 2x half-band stage; ce_in runs at the output rate of the stage
module dind_halfband #(
  parameter int STAGE = 1,
  parameter int TAPS  = 55,
  parameter int SHIFT = 15
) (
  // Clock and reset
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  // Stream
  input  wire logic            ce_in,
  input  wire dind_pkg::dind_iq_t x_in,
  output dind_pkg::dind_iq_t   y_out
);

  localparam int L = (TAPS + 1) / 2;
  localparam int MID = L / 2 - 1;

  logic signed [15:0] i_line_q [L];
  logic signed [15:0] q_line_q [L];
  logic               phase_q;
  logic signed [39:0] i_acc;
  logic signed [39:0] q_acc;
  logic signed [39:0] i_ctr;
  logic signed [39:0] q_ctr;
  logic signed [17:0] ctr;
  dind_pkg::dind_iq_t y_q;

  assign ctr = (STAGE == 1) ? dind_pkg::HB1_CTR :
               (STAGE == 2) ? dind_pkg::HB2_CTR : dind_pkg::HB3_CTR;

  // I and Q through separate real accumulators
  always_comb
  begin
    i_acc = '0;
    q_acc = '0;
    for (int k = 0; k < L; k++)
    begin
      i_acc = i_acc + 40'(i_line_q[k] * dind_pkg::dind_hb_coef(STAGE, (k < L/2) ? k : L-1-k));
      q_acc = q_acc + 40'(q_line_q[k] * dind_pkg::dind_hb_coef(STAGE, (k < L/2) ? k : L-1-k));
    end
  end

  assign i_ctr = 40'(i_line_q[MID] * ctr);
  assign q_ctr = 40'(q_line_q[MID] * ctr);

  // Phase 0 shifts and emits centre tap, phase 1 emits the odd-tap sum
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_q <= 1'b0;
      y_q     <= '0;
      for (int k = 0; k < L; k++)
      begin
        i_line_q[k] <= '0;
        q_line_q[k] <= '0;
      end
    end
    else if (ce_in)
    begin
      phase_q <= ~phase_q;
      if (!phase_q)
      begin
        y_q.i <= dind_pkg::dind_sat16(i_ctr >>> SHIFT);
        y_q.q <= dind_pkg::dind_sat16(q_ctr >>> SHIFT);
        i_line_q[0] <= x_in.i;
        q_line_q[0] <= x_in.q;
        for (int k = 1; k < L; k++)
        begin
          i_line_q[k] <= i_line_q[k-1];
          q_line_q[k] <= q_line_q[k-1];
        end
      end
      else
      begin
        y_q.i <= dind_pkg::dind_sat16(i_acc >>> SHIFT);
        y_q.q <= dind_pkg::dind_sat16(q_acc >>> SHIFT);
      end
    end
  end

  assign y_out = y_q;

endmodule : dind_halfband

// ==== verilog/dind_datapath.sv ====
`timescale 1ns/1ps
module dind_datapath (
  // Clock and reset
  input  wire logic               sys_clk_in,
  input  wire logic               rst_in,
  // Serial-port register access
  input  wire logic [7:0]         reg_addr_in,
  input  wire logic [7:0]         reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output logic [7:0]              reg_rdata_out,
  // Baseband samples
  input  wire dind_pkg::dind_iq_t sample_in,
  output logic                    sample_take_out,
  // Frame pin and modulation select
  input  wire logic               frame_pin_in,
  input  wire logic [1:0]         mod_mode_in,
  // Converter samples
  output dind_pkg::dind_iq_t      dac_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [1:0]  action_q;
  logic        repeat_strobe_enable_q;
  logic [1:0]  ratio_q;
  logic        serial_retune_request_q;
  logic        req_prev_q;
  logic        serial_retune_acknowledge_q;
  logic        strobe_retune_acknowledge_q;
  logic        armed_q;
  logic [7:0]  word_byte_q [4];
  logic [31:0] carrier_step_word;
  logic [31:0] active_word_q;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;

  logic wr_frame;
  logic wr_ratio;
  logic wr_upd;
  logic req_rise;
  logic req_fall;
  logic spi_load;
  logic frame_load;
  logic tune_load;

  assign wr_frame = reg_wr_in && (reg_addr_in == dind_pkg::ADDR_FRAME_CFG);
  assign wr_ratio = reg_wr_in && (reg_addr_in == dind_pkg::ADDR_RATIO);
  assign wr_upd   = reg_wr_in && (reg_addr_in == dind_pkg::ADDR_UPD_CTRL);

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      action_q               <= dind_pkg::RST_FRAME_CFG[1:0];
      repeat_strobe_enable_q <= dind_pkg::RST_FRAME_CFG[dind_pkg::FRM_REPEAT_BIT];
      ratio_q                <= dind_pkg::RST_RATIO;
      serial_retune_request_q <= 1'b0;
    end
    else
    begin
      if (wr_frame)
      begin
        action_q               <= reg_wdata_in[dind_pkg::FRM_ACTION_LSB +: 2];
        repeat_strobe_enable_q <= reg_wdata_in[dind_pkg::FRM_REPEAT_BIT];
      end
      if (wr_ratio)
        ratio_q <= reg_wdata_in[1:0];
      if (wr_upd)
        serial_retune_request_q <= reg_wdata_in[dind_pkg::UPD_REQ_BIT];
    end
  end

  // Shadow bytes; byte a is the least significant
  generate
    for (genvar b = 0; b < 4; b++)
    begin : g_word
      always_ff @(posedge sys_clk_in or posedge rst_in)
      begin
        if (rst_in)
          word_byte_q[b] <= dind_pkg::RST_WORD_BYTE;
        else if (reg_wr_in && (reg_addr_in == dind_pkg::ADDR_WORD_A + 8'(b)))
          word_byte_q[b] <= reg_wdata_in;
      end
      assign carrier_step_word[8*b +: 8] = word_byte_q[b];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Update handshakes

  logic       frame_s1_q;
  logic       frame_s2_q;
  logic [3:0] frame_hi_q;
  logic       frame_valid;
  logic       nco_by_frame;

  assign req_rise = serial_retune_request_q && !req_prev_q;
  assign req_fall = !serial_retune_request_q && req_prev_q;
  assign spi_load = req_rise;

  // Pulse must last one input period before it counts
  assign frame_valid  = frame_s2_q && (frame_hi_q == 4'((1 << ratio_q) - 1));
  assign nco_by_frame = (action_q == dind_pkg::ACT_NCO) || (action_q == dind_pkg::ACT_BOTH);
  assign frame_load   = frame_valid && nco_by_frame &&
                        (armed_q || repeat_strobe_enable_q);
  assign tune_load    = spi_load || frame_load;

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      frame_s1_q <= 1'b0;
      frame_s2_q <= 1'b0;
      frame_hi_q <= 4'h0;
    end
    else
    begin
      frame_s1_q <= frame_pin_in;
      frame_s2_q <= frame_s1_q;
      if (!frame_s2_q)
        frame_hi_q <= 4'h0;
      else if (frame_hi_q != 4'hF)
        frame_hi_q <= frame_hi_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      req_prev_q                  <= 1'b0;
      serial_retune_acknowledge_q <= 1'b0;
      strobe_retune_acknowledge_q <= 1'b0;
      armed_q                     <= 1'b0;
      active_word_q               <= '0;
    end
    else
    begin
      req_prev_q <= serial_retune_request_q;
      if (req_rise)
        serial_retune_acknowledge_q <= 1'b1;
      else if (req_fall)
        serial_retune_acknowledge_q <= 1'b0;
      // Rewriting the action field re-arms one-shot; the write wins the arm
      if (wr_frame)
        armed_q <= 1'b1;
      else if (frame_load)
        armed_q <= 1'b0;
      if (frame_load)
        strobe_retune_acknowledge_q <= 1'b1;
      else if (wr_frame)
        strobe_retune_acknowledge_q <= 1'b0;
      if (tune_load)
        active_word_q <= carrier_step_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read

  always_comb
  begin
    rdata_d = 8'h00;
    unique case (reg_addr_in)
      dind_pkg::ADDR_FRAME_CFG: rdata_d = {5'h00, repeat_strobe_enable_q, action_q};
      dind_pkg::ADDR_RATIO:     rdata_d = {6'h00, ratio_q};
      dind_pkg::ADDR_UPD_CTRL:  rdata_d = {1'b0, strobe_retune_acknowledge_q, 4'h0,
                                           serial_retune_acknowledge_q,
                                           serial_retune_request_q};
      8'h31, 8'h32, 8'h33, 8'h34: rdata_d = word_byte_q[2'(reg_addr_in - dind_pkg::ADDR_WORD_A)];
      default:                  rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_q <= 8'h00;
    else if (reg_rd_in)
      rdata_q <= rdata_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interpolation chain

  logic [2:0]         cnt_q;
  logic               in_ce;
  logic [3:1]         hb_ce;
  logic               take_q;
  dind_pkg::dind_iq_t in_q;
  dind_pkg::dind_iq_t hb_y [4];
  dind_pkg::dind_iq_t base;

  assign in_ce = dind_pkg::dind_strobe(cnt_q, int'(ratio_q));

  // Unused stages never see a strobe, so they sit idle
  generate
    for (genvar s = 1; s <= 3; s++)
    begin : g_hb
      assign hb_ce[s] = (int'(ratio_q) >= s) &&
                        dind_pkg::dind_strobe(cnt_q, int'(ratio_q) - s);
      dind_halfband #(
        .STAGE (s),
        .TAPS  ((s == 1) ? dind_pkg::HB1_TAPS :
                (s == 2) ? dind_pkg::HB2_TAPS : dind_pkg::HB3_TAPS),
        .SHIFT ((s == 1) ? 15 : (s == 2) ? 12 : 11)
      ) u_hb (
        .clk_in (sys_clk_in),
        .rst_in (rst_in),
        .ce_in  (hb_ce[s]),
        .x_in   (hb_y[s-1]),
        .y_out  (hb_y[s])
      );
    end
  endgenerate

  assign hb_y[0] = in_q;
  assign base    = hb_y[ratio_q];

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q  <= 3'h0;
      take_q <= 1'b0;
      in_q   <= '0;
    end
    else
    begin
      cnt_q  <= cnt_q + 3'h1;
      take_q <= in_ce;
      if (in_ce)
        in_q <= sample_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulation

  logic [31:0]        phase_q;
  logic signed [17:0] sin_v;
  logic signed [17:0] cos_v;
  logic signed [39:0] mix_i;
  logic signed [39:0] mix_q;
  dind_pkg::dind_iq_t fs4;
  dind_pkg::dind_iq_t dac_d;
  dind_pkg::dind_iq_t dac_q;
  dind_pkg::dind_mod_t mode;

  assign mode  = dind_pkg::dind_mod_t'(mod_mode_in);
  assign sin_v = dind_pkg::dind_sine(phase_q[31:26]);
  assign cos_v = dind_pkg::dind_sine(phase_q[31:26] + 6'h10);
  assign mix_i = 40'(base.i * cos_v) - 40'(base.q * sin_v);
  assign mix_q = 40'(base.i * sin_v) + 40'(base.q * cos_v);

  // Complex rotation by j per converter cycle; -full-scale wraps
  always_comb
  begin
    unique case (cnt_q[1:0])
      2'h0: fs4 = base;
      2'h1: fs4 = '{i: -base.q, q: base.i};
      2'h2: fs4 = '{i: -base.i, q: -base.q};
      2'h3: fs4 = '{i: base.q, q: -base.i};
    endcase
  end

  always_comb
  begin
    unique case (mode)
      dind_pkg::DIND_MOD_FS4: dac_d = fs4;
      dind_pkg::DIND_MOD_NCO: dac_d = '{i: dind_pkg::dind_sat16(mix_i >>> dind_pkg::SINE_SHIFT),
                                        q: dind_pkg::dind_sat16(mix_q >>> dind_pkg::SINE_SHIFT)};
      default:                dac_d = base;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_q <= '0;
      dac_q   <= '0;
    end
    else
    begin
      phase_q <= phase_q + active_word_q;
      dac_q   <= dac_d;
    end
  end

  assign dac_out         = dac_q;
  assign sample_take_out = take_q;
  assign reg_rdata_out   = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_ack_rise;
    @(posedge sys_clk_in) disable iff (rst_in)
      $rose(serial_retune_request_q) |=> serial_retune_acknowledge_q
        && active_word_q == $past(carrier_step_word);
  endproperty
  a_ack_rise: assert property (p_ack_rise)
    else $error("request rise did not load and acknowledge");

  property p_ack_fall;
    @(posedge sys_clk_in) disable iff (rst_in)
      $fell(serial_retune_request_q) |=> !serial_retune_acknowledge_q;
  endproperty
  a_ack_fall: assert property (p_ack_fall)
    else $error("request fall did not clear acknowledge");

  property p_shadow_hold;
    @(posedge sys_clk_in) disable iff (rst_in)
      !tune_load |=> $stable(active_word_q);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold)
    else $error("active word changed without an update");

  property p_word_bytes;
    @(posedge sys_clk_in) disable iff (rst_in)
      reg_wr_in && reg_addr_in == dind_pkg::ADDR_WORD_D |=>
        carrier_step_word[31:24] == $past(reg_wdata_in);
  endproperty
  a_word_bytes: assert property (p_word_bytes)
    else $error("top tuning byte not stored");

  property p_phase_step;
    @(posedge sys_clk_in) disable iff (rst_in)
      ##1 phase_q == $past(phase_q) + $past(active_word_q);
  endproperty
  a_phase_step: assert property (p_phase_step)
    else $error("oscillator phase did not advance by the word");

  property p_frame_ack;
    @(posedge sys_clk_in) disable iff (rst_in)
      frame_valid && nco_by_frame && armed_q |=> strobe_retune_acknowledge_q
        && active_word_q == $past(carrier_step_word);
  endproperty
  a_frame_ack: assert property (p_frame_ack)
    else $error("valid frame pulse did not update");

  property p_one_shot;
    @(posedge sys_clk_in) disable iff (rst_in)
      frame_load && !repeat_strobe_enable_q && !wr_frame |=> !armed_q;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("one-shot stayed armed after a frame update");

  property p_in_rate8;
    @(posedge sys_clk_in) disable iff (rst_in)
      in_ce && ratio_q == dind_pkg::DIND_R8 |=> (!in_ce || ratio_q != dind_pkg::DIND_R8) [*7];
  endproperty
  a_in_rate8: assert property (p_in_rate8)
    else $error("8x input taken faster than one in eight");

  property p_fs4;
    @(posedge sys_clk_in) disable iff (rst_in)
      mode == dind_pkg::DIND_MOD_FS4 && cnt_q[1:0] == 2'h2 |=> dac_q.q == -$past(base.q);
  endproperty
  a_fs4: assert property (p_fs4)
    else $error("quarter-rate rotation wrong");

endmodule : dind_datapath

// ==== tb/dind_bb_model.sv ====
`timescale 1ns/1ps
module dind_bb_model (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  // Control from the bench
  input  wire logic               take_in,
  input  wire dind_pkg::dind_iq_t next_in,
  input  wire logic               frame_go_in,
  input  wire logic [3:0]         frame_len_in,
  // Toward the datapath
  output dind_pkg::dind_iq_t      sample_out,
  output logic                    frame_out
);
  logic [3:0] frm_cnt_q;
  ////////////////////////////////////////
  // New sample only after a take, so it is stable at every capture edge
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      sample_out <= '0;
    else if (take_in)
      sample_out <= next_in;
  end
  // Pulse is never shortened below the requested length
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      frm_cnt_q <= 4'h0;
      frame_out <= 1'b0;
    end
    else if (frame_go_in)
    begin
      frm_cnt_q <= frame_len_in;
      frame_out <= 1'b1;
    end
    else if (frm_cnt_q > 4'h1)
      frm_cnt_q <= frm_cnt_q - 4'h1;
    else
    begin
      frm_cnt_q <= 4'h0;
      frame_out <= 1'b0;
    end
  end
endmodule : dind_bb_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } dind_row_t;
  localparam int LIMIT = 6000;
  localparam dind_row_t ROWS [7] = '{'{8'h31, 8'hA5, 8'hA5}, '{8'h32, 8'h5A, 8'h5A},
    '{8'h33, 8'h0F, 8'h0F}, '{8'h34, 8'hF0, 8'hF0}, '{8'h22, 8'h04, 8'h04},
    '{8'h28, 8'h03, 8'h03}, '{8'hFF, 8'h5A, 8'h00}};
  logic               sys_clk_in;
  logic               rst_in;
  logic               reg_wr_in;
  logic               reg_rd_in;
  logic               frame_pin_in;
  logic               frame_go;
  logic               take;
  logic [7:0]         reg_addr_in;
  logic [7:0]         reg_wdata_in;
  logic [7:0]         reg_rdata_out;
  logic [1:0]         mod_mode_in;
  logic [3:0]         frame_len;
  logic signed [15:0] a_i;
  dind_pkg::dind_iq_t sample_in;
  dind_pkg::dind_iq_t dac_out;
  dind_pkg::dind_iq_t next_smp;
  int                 error_cnt;
  int                 total_checks;
  int                 cycles;
  int                 gap;
  ////////////////////////////////////////
  dind_datapath dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .sample_in(sample_in), .sample_take_out(take),
    .frame_pin_in(frame_pin_in), .mod_mode_in(mod_mode_in), .dac_out(dac_out));
  dind_bb_model bb_u (.clk_in(sys_clk_in), .rst_in(rst_in), .take_in(take),
    .next_in(next_smp), .frame_go_in(frame_go), .frame_len_in(frame_len),
    .sample_out(sample_in), .frame_out(frame_pin_in));
  initial
  begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      error_cnt++;
      close_out();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk_in);
    reg_addr_in  <= addr;
    reg_wdata_in <= data;
    reg_wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge sys_clk_in);
    reg_addr_in <= addr;
    reg_rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in   <= 1'b0;
    #1;
    chk("reg_rdata", {24'h000000, exp}, {24'h000000, reg_rdata_out});
  endtask : rd_chk
  task automatic wr_word(input logic [31:0] w);
    for (int b = 0; b < 4; b++)
      wr(8'h31 + 8'(b), w[8*b +: 8]);
  endtask : wr_word
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : settle
  // A pure carrier flips sign after half its period whatever the start phase
  task automatic rot(input int step);
    settle(1);
    a_i = dac_out.i;
    settle(step);
    chk("rot_i", {15'h0000, a_i == 16'sh0000, 16'(-a_i)}, {16'h0000, dac_out.i});
  endtask : rot
  task automatic pulse();
    @(posedge sys_clk_in);
    frame_go <= 1'b1;
    @(posedge sys_clk_in);
    frame_go <= 1'b0;
    settle(14);
  endtask : pulse
  task automatic close_out();
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  ////////////////////////////////////////
  initial
  begin
    rst_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    mod_mode_in = 2'h0;
    frame_go = 1'b0;
    frame_len = 4'h4;
    next_smp = {16'sh03E8, 16'sh01F4};
    error_cnt = 0;
    total_checks = 0;
    settle(6);
    chk("dac_in_reset", 32'h00000000, dac_out);
    rst_in <= 1'b0;
    rd_chk(8'h22, 8'h00);
    rd_chk(8'h28, 8'h01);
    rd_chk(8'h30, 8'h00);
    for (int b = 0; b < 4; b++)
      rd_chk(8'h31 + 8'(b), 8'h00);
    foreach (ROWS[k])
    begin
      wr(ROWS[k].addr, ROWS[k].wdata);
      rd_chk(ROWS[k].addr, ROWS[k].exp);
    end
    wr(8'h22, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h28, 8'(c));
      settle(2);
      for (int n = 0; n < 20 && take !== 1'b1; n++)
        settle(1);
      gap = 0;
      do
      begin
        settle(1);
        gap++;
      end while (take !== 1'b1 && gap < 20);
      chk("take_gap", 32'(1 << c), 32'(gap));
      // Odd taps sum to the centre tap, so a flushed chain passes dc unchanged
      settle(300);
      chk("dac_dc", next_smp, dac_out);
    end
    wr(8'h28, 8'h00);
    settle(12);
    chk("dac_bypass", next_smp, dac_out);
    mod_mode_in <= 2'h1;
    settle(8);
    rot(2);
    mod_mode_in <= 2'h2;
    settle(8);
    chk("dac_nco_idle", next_smp, dac_out);
    wr_word(32'h40000000);
    settle(8);
    chk("dac_shadow", next_smp, dac_out);
    wr(8'h30, 8'h01);
    settle(3);
    rd_chk(8'h30, 8'h03);
    settle(8);
    rot(2);
    wr(8'h30, 8'h00);
    settle(3);
    rd_chk(8'h30, 8'h00);
    wr_word(32'h80000000);
    wr(8'h22, 8'h01);
    pulse();
    rd_chk(8'h30, 8'h40);
    rot(1);
    wr_word(32'h40000000);
    pulse();
    rot(1);
    wr(8'h22, 8'h02);
    settle(2);
    rd_chk(8'h30, 8'h00);
    pulse();
    rot(2);
    rd_chk(8'h30, 8'h40);
    wr_word(32'hC0000000);
    wr(8'h22, 8'h05);
    pulse();
    rot(2);
    wr_word(32'h80000000);
    pulse();
    rot(1);
    close_out();
  end
endmodule : testbench
